// File: core/lpp_params.svh
`ifndef LPP_PARAMS_SVH
`define LPP_PARAMS_SVH
// storage sizes
`define LPP_IN_DEPTH   5
`define LPP_IN_WIDTH   32
`define LPP_PIN_DEPTH  19
`define LPP_PIN_WIDTH  18
`define LPP_PAL_SIZE   256
`define LPP_PAL_WIDTH  12
// pixel clock divisor: core clock / (div + 6), div 0..511
`define LPP_DIV_MIN    6
`define LPP_DIV_BITS   9
// dither: phases 0..14 give 15 levels
`define LPP_DITHER_PH  15
// register byte addresses (12-bit bus)
`define LPP_A_CTRL     12'h000
`define LPP_A_DIV      12'h004
`define LPP_A_SIZE     12'h008
`define LPP_A_STAT     12'h00c
`define LPP_PAL_SEL    10
// control field positions
`define LPP_C_EN       0
`define LPP_C_BPP      1
`define LPP_C_COLOR    3
`define LPP_C_ACTIVE   4
`define LPP_C_DUAL     5
`define LPP_C_MONO8    6
// size field positions
`define LPP_S_HGT      16
`endif

// File: core/lpp_pkg.sv
`include "lpp_params.svh"
package lpp_pkg;
	// encoded pixel size as written by software
	typedef enum logic [1:0] {LPP_BPP4, LPP_BPP8, LPP_BPP12, LPP_BPP16} lpp_bpp_t;

	typedef struct packed {
		logic                                         en;
		lpp_bpp_t                                     bpp;
		logic                                         color;
		logic                                         active;
		logic                                         dual;
		logic                                         mono8;
		logic [`LPP_DIV_BITS-1:0]                     div;
		logic [9:0]                                   wid;
		logic [9:0]                                   hgt;
		logic                                         unr;
		logic                                         started;
		logic [`LPP_PAL_SIZE-1:0][`LPP_PAL_WIDTH-1:0] pal;
		logic [`LPP_IN_DEPTH-1:0][`LPP_IN_WIDTH-1:0]  ifq;
		logic [2:0]                                   icnt;
		logic [2:0]                                   ipos;
		logic [`LPP_PIN_DEPTH-1:0][`LPP_PIN_WIDTH-1:0] pfq;
		logic [4:0]                                   prd;
		logic [4:0]                                   pwr;
		logic [4:0]                                   pcnt;
		logic [9:0]                                   acc0;
		logic [9:0]                                   acc1;
		logic [3:0]                                   c0;
		logic [3:0]                                   c1;
		logic                                         lane;
		logic [9:0]                                   col;
		logic [9:0]                                   row;
		logic [3:0]                                   fph;
		logic                                         lend;
		logic                                         fst;
		logic [9:0]                                   dcnt;
		logic                                         slot;
		logic                                         pclk;
		logic [15:0]                                  dout;
		logic                                         lclk;
		logic                                         fclk;
		logic                                         bias;
		logic [31:0]                                  rdata;
	} lpp_state_t;
endpackage

// File: core/lpp_pipeline.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Function
// - passive color: 3375 colors, 256 per frame
// - active color: 16-bit pixels, 65536 colors
// - panels up to 1024x1024, single or dual
// - one DMA channel single, two for dual
// - input FIFO five 32-bit entries, on demand
// - unpack 4, 8, 12 or 16-bit pixels
// - palette 256 entries of 12 bits
// - monochrome uses 4 palette bits only
// - 4-bit pixels index bottom 16 entries
// - passive 12-bit pixels skip palette
// - active 16-bit pixels skip palette, dither
// - dither gives 15 levels per component
// - dither output queued in 19-entry FIFO
// - drive 4, 8 or 16 data lines
// - mono 4/8 pixels, color 2-2/3 per clock
// - passive color: three lines per pixel RGB
// - dual panel splits lines upper/lower halves
// - TFT: line=hsync, frame=vsync, bias=enable
// - TFT bypasses dither, sends palette entries
// - single mono uses low four lines only; with mono8 set single mono drives all eight
// - dual color, 16-bit TFT use extra pins
// - disabled pins go to pin controller
// - RGB output only, no composite video
// - DMA request when four entries empty
// - underrun sets flag, raises interrupt request
// - pixel clock divides core clock 6..517
module lpp_pipeline (
	input  wire logic        ref_clk_i,            // core clock
	input  wire logic        rst_i,                // async reset, high
	input  wire logic [11:0] addr_i,               // register byte address
	input  wire logic [31:0] wdata_i,              // register write data
	input  wire logic        wr_i,                 // write strobe
	input  wire logic        rd_i,                 // read strobe
	output logic      [31:0] rdata_o,              // read data, next cycle
	input  wire logic        in_valid_i,           // dma word valid
	input  wire logic [31:0] in_data_i,            // dma word
	output logic             in_ready_o,           // input fifo has room
	output logic      [1:0]  dma_req_o,            // service request per channel
	output logic             underrun_irq_o,       // underrun request
	output logic      [7:0]  display_data_lines_o, // panel data lines
	output logic      [7:0]  data_oe_o,            // data line enables
	output logic      [7:0]  gp_data_o,            // extra data on gp pins 9:2
	output logic      [7:0]  gp_oe_o,              // gp pin enables
	output logic             pclk_o,               // pixel clock
	output logic             lclk_o,               // line clock / hsync
	output logic             fclk_o,               // frame clock / vsync
	output logic             bias_o,               // ac bias / output enable
	output logic             ctl_oe_o,             // control pin enable
	output logic             ppc_own_o             // pins owned by pin controller
);
	import lpp_pkg::*;

	lpp_state_t s;
	lpp_state_t n;

	logic        step;
	logic        last;
	logic        in_push;
	logic        in_pop;
	logic        push;
	logic        pop;
	logic        w8;
	logic        colinc;
	logic        eol;
	logic        eof;
	logic        lp;
	logic [3:0]  wd;
	logic [31:0] wsh;
	logic [15:0] e;
	logic [11:0] pe;
	logic [11:0] cv;
	logic [2:0]  b3;
	logic [3:0]  nb;
	logic [15:0] pw;
	logic [9:0]  half;

	// phase for dithering, wrapped into 0..14
	function automatic logic [3:0] lpp_ph(input logic [5:0] v);
		logic [5:0] r;
		r = v;
		if (r >= 6'd30)
			r = r - 6'd30;
		else if (r >= 6'(`LPP_DITHER_PH))
			r = r - 6'(`LPP_DITHER_PH);
		return r[3:0];
	endfunction

	// pixel on in this frame: level 15 always, 0 never
	function automatic logic lpp_on(input logic [3:0] v, input logic [3:0] ph);
		return (v == 4'hf) || (ph < v);
	endfunction

	// next-state logic for the whole block
	always_comb
	begin
		n = s;
		step = 1'b0;
		last = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		pw = 16'h0000;
		colinc = 1'b0;
		eol = 1'b0;
		eof = 1'b0;
		wd = 4'h4;
		half = 10'(s.div) + 10'(`LPP_DIV_MIN);
		half = half >> 1;

		// register writes; palette window when bit 10 set
		if (wr_i)
		begin
			if (addr_i[`LPP_PAL_SEL])
				n.pal[addr_i[9:2]] = wdata_i[11:0];
			else if (addr_i == `LPP_A_CTRL)
			begin
				n.en = wdata_i[`LPP_C_EN];
				n.bpp = lpp_bpp_t'(wdata_i[`LPP_C_BPP +: 2]);
				n.color = wdata_i[`LPP_C_COLOR];
				n.active = wdata_i[`LPP_C_ACTIVE];
				n.dual = wdata_i[`LPP_C_DUAL];
				n.mono8 = wdata_i[`LPP_C_MONO8];
			end
			else if (addr_i == `LPP_A_DIV)
				n.div = wdata_i[`LPP_DIV_BITS-1:0];
			else if (addr_i == `LPP_A_SIZE)
			begin
				n.wid = wdata_i[9:0];
				n.hgt = wdata_i[`LPP_S_HGT +: 10];
			end
			else if (addr_i == `LPP_A_STAT)
			begin
				if (wdata_i[0])
					n.unr = 1'b0; // write one to clear
			end
		end

		// read data stands one cycle after the strobe
		n.rdata = 32'h0000_0000;
		if (rd_i)
		begin
			if (addr_i[`LPP_PAL_SEL])
				n.rdata = {20'h00000, s.pal[addr_i[9:2]]};
			else if (addr_i == `LPP_A_CTRL)
				n.rdata = {25'h0, s.mono8, s.dual, s.active, s.color, s.bpp, s.en};
			else if (addr_i == `LPP_A_DIV)
				n.rdata = {23'h0, s.div};
			else if (addr_i == `LPP_A_SIZE)
				n.rdata = {6'h00, s.hgt, 6'h00, s.wid};
			else if (addr_i == `LPP_A_STAT)
				n.rdata = {23'h0, s.pcnt, s.icnt, s.unr};
		end

		// unpack the bottom input word
		step = s.en && (s.icnt != 3'd0) && (s.pcnt != 5'(`LPP_PIN_DEPTH));
		case (s.bpp)
			LPP_BPP4:
			begin
				wsh = s.ifq[0] >> {s.ipos, 2'b00};
				last = (s.ipos == 3'd7);
			end
			LPP_BPP8:
			begin
				wsh = s.ifq[0] >> {s.ipos, 3'b000};
				last = (s.ipos == 3'd3);
			end
			default:
			begin
				// 12-bit pixels sit in half-word slots
				wsh = s.ifq[0] >> {s.ipos, 4'h0};
				last = (s.ipos == 3'd1);
			end
		endcase
		e = wsh[15:0];

		// 4-bit codes reach only entries 0..15
		pe = (s.bpp == LPP_BPP4) ? s.pal[{4'h0, e[3:0]}] : s.pal[e[7:0]];
		cv = (s.bpp == LPP_BPP12) ? e[11:0] : pe;

		// space and time dither; spatial offset per component
		if (s.color)
		begin
			b3[0] = lpp_on(cv[11:8], lpp_ph(6'(s.fph) + 6'(s.col[3:0])));
			b3[1] = lpp_on(cv[7:4], lpp_ph(6'(s.fph) + 6'(s.col[3:0]) + 6'd5));
			b3[2] = lpp_on(cv[3:0], lpp_ph(6'(s.fph) + 6'(s.col[3:0]) + 6'd10));
			nb = 4'h3;
		end
		else
		begin
			b3 = {2'b00, lpp_on(cv[3:0], lpp_ph(6'(s.fph) + 6'(s.col[3:0])))};
			nb = 4'h1;
		end

		// lane width: color 8 lines, mono 4 or 8
		w8 = s.dual ? s.color : (s.mono8 || s.color);
		if (w8)
			wd = 4'h8;

		// screen position; dual alternates upper and lower
		if (step)
		begin
			n.ipos = last ? 3'd0 : s.ipos + 3'd1;
			colinc = !s.dual || s.lane;
			if (s.dual)
				n.lane = ~s.lane;
			eol = colinc && (s.col == s.wid);
			eof = eol && (s.row == s.hgt);
			if (colinc)
				n.col = eol ? 10'h000 : s.col + 10'h001;
			if (eol)
				n.row = eof ? 10'h000 : s.row + 10'h001;
			if (eof)
				n.fph = lpp_ph(6'(s.fph) + 6'h01);
			if (!s.active)
			begin
				if (s.lane)
				begin
					n.acc1 = s.acc1 | (10'(b3) << s.c1);
					n.c1 = s.c1 + nb;
				end
				else
				begin
					n.acc0 = s.acc0 | (10'(b3) << s.c0);
					n.c0 = s.c0 + nb;
				end
			end
		end

		// build a pin word: TFT one pixel, passive full lanes
		if (step && s.active)
		begin
			push = 1'b1;
			pw = (s.bpp == LPP_BPP16) ? e : {4'h0, pe};
		end
		else if (!s.active && (n.c0 >= wd) && (!s.dual || n.c1 >= wd))
		begin
			push = 1'b1;
			if (s.dual && w8)
				pw = {n.acc1[7:0], n.acc0[7:0]};
			else if (s.dual)
				pw = {8'h00, n.acc1[3:0], n.acc0[3:0]};
			else if (w8)
				pw = {8'h00, n.acc0[7:0]};
			else
				pw = {12'h000, n.acc0[3:0]};
			n.acc0 = n.acc0 >> wd;
			n.acc1 = n.acc1 >> wd;
			n.c0 = n.c0 - wd;
			n.c1 = s.dual ? n.c1 - wd : 4'h0;
		end

		// line and frame marks ride with the pin word
		lp = s.lend || eol;
		n.lend = push ? 1'b0 : lp;
		if (push)
		begin
			n.pfq[s.pwr] = {s.fst, lp, pw};
			n.pwr = (s.pwr == 5'(`LPP_PIN_DEPTH - 1)) ? 5'd0 : s.pwr + 5'd1;
			n.fst = 1'b0;
		end
		if (eof)
			n.fst = 1'b1;

		// input fifo: bottom leaves, rest moves down
		in_pop = step && last;
		in_push = in_valid_i && s.en && (s.icnt != 3'(`LPP_IN_DEPTH));
		if (in_pop)
		begin
			for (int i = 0; i < `LPP_IN_DEPTH - 1; i++)
				n.ifq[i] = s.ifq[i+1];
		end
		if (in_push)
		begin
			n.ifq[s.icnt - 3'(in_pop)] = in_data_i;
			n.started = 1'b1;
		end
		n.icnt = s.icnt + 3'(in_push) - 3'(in_pop);

		// underrun: fetch fell behind once running; set beats clear
		if (s.en && s.started && (s.icnt == 3'd0) && !in_push && (s.pcnt != 5'(`LPP_PIN_DEPTH)))
			n.unr = 1'b1;

		// pixel clock: period div+6 core cycles
		n.dcnt = (s.dcnt == 10'(s.div) + 10'(`LPP_DIV_MIN - 1)) ? 10'h000 : s.dcnt + 10'h001;
		if (s.dcnt == 10'h000)
		begin
			n.pclk = 1'b0;
			if (s.pcnt != 5'd0)
			begin
				pop = 1'b1;
				n.slot = 1'b1;
				n.dout = s.pfq[s.prd][15:0];
				n.lclk = s.pfq[s.prd][16];
				n.fclk = s.pfq[s.prd][17];
				// passive bias flips each frame against dc offset
				if (s.active)
					n.bias = 1'b1;
				else if (s.pfq[s.prd][17])
					n.bias = ~s.bias;
				n.prd = (s.prd == 5'(`LPP_PIN_DEPTH - 1)) ? 5'd0 : s.prd + 5'd1;
			end
			else
			begin
				n.slot = 1'b0;
				n.lclk = 1'b0;
				n.fclk = 1'b0;
				if (s.active)
					n.bias = 1'b0;
			end
		end
		else if (s.dcnt == half)
		begin
			// passive clock moves only with data; TFT runs free
			if (s.active || s.slot)
				n.pclk = 1'b1;
		end
		n.pcnt = s.pcnt + 5'(push) - 5'(pop);

		// disabled: pipeline idles empty, ready for a fresh frame
		if (!s.en)
		begin
			n.icnt = 3'd0;
			n.ipos = 3'd0;
			n.pcnt = 5'd0;
			n.prd = 5'd0;
			n.pwr = 5'd0;
			n.acc0 = 10'h000;
			n.acc1 = 10'h000;
			n.c0 = 4'h0;
			n.c1 = 4'h0;
			n.lane = 1'b0;
			n.col = 10'h000;
			n.row = 10'h000;
			n.lend = 1'b0;
			n.fst = 1'b1;
			n.started = 1'b0;
			n.dcnt = 10'h000;
			n.slot = 1'b0;
			n.pclk = 1'b0;
			n.lclk = 1'b0;
			n.fclk = 1'b0;
			n.bias = 1'b0;
			n.dout = 16'h0000;
		end
	end

	// state register; everything clears so the block starts disabled
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			s <= '0;
		else
			s <= n;
	end

	// outputs; four-of-five empty raises the request
	assign rdata_o = s.rdata;
	assign in_ready_o = s.en && (s.icnt != 3'(`LPP_IN_DEPTH));
	assign dma_req_o[0] = s.en && (s.icnt <= 3'd1);
	assign dma_req_o[1] = s.en && s.dual && (s.icnt <= 3'd1);
	assign underrun_irq_o = s.unr;

	// plain RGB levels only; no composite encoding here
	assign display_data_lines_o = s.dout[7:0];
	assign gp_data_o = s.dout[15:8];
	assign pclk_o = s.pclk;
	assign lclk_o = s.lclk;
	assign fclk_o = s.fclk;
	assign bias_o = s.bias;

	// pin ownership and line usage per mode
	assign ppc_own_o = !s.en;
	assign ctl_oe_o = s.en;
	assign data_oe_o = !s.en ? 8'h00 : ((!s.dual && !w8 && !s.active) ? 8'h0f : 8'hff);
	assign gp_oe_o = (s.en && (s.active || (s.dual && s.color))) ? 8'hff : 8'h00;
endmodule

// File: testbench/lpp_pipeline_chk.sv
`timescale 1ns/1ps
module lpp_pipeline_chk (
	input wire logic        ref_clk_i,            // core clock
	input wire logic        rst_i,                // async reset
	input wire logic        wr_i,                 // write strobe
	input wire logic        rd_i,                 // read strobe
	input wire logic [31:0] rdata_o,              // read data
	input wire logic        in_ready_o,           // fifo room
	input wire logic [1:0]  dma_req_o,            // requests
	input wire logic        underrun_irq_o,       // underrun
	input wire logic [7:0]  display_data_lines_o, // data lines
	input wire logic [7:0]  data_oe_o,            // data enables
	input wire logic [7:0]  gp_oe_o,              // gp enables
	input wire logic        pclk_o,               // pixel clock
	input wire logic        ctl_oe_o,             // control enable
	input wire logic        ppc_own_o             // pin controller owns
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	// ownership and drive
	chk_own_vs_ctl: assert property (ppc_own_o == !ctl_oe_o) else $error("own and enable disagree");
	chk_off_no_drive: assert property (ppc_own_o |-> data_oe_o == 0 && gp_oe_o == 0 && !in_ready_o && dma_req_o == 0) else $error("disabled block drives");
	chk_line_set: assert property (ctl_oe_o |-> data_oe_o inside {8'h0f, 8'hff}) else $error("bad line set");
	chk_gp_full: assert property (gp_oe_o != 0 |-> gp_oe_o == 8'hff && data_oe_o == 8'hff) else $error("gp pins partial");
	chk_req_pair: assert property (dma_req_o[1] |-> dma_req_o[0]) else $error("second channel alone");
	// read data stands only after a read
	chk_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 0) else $error("read data without read");
	// half period never below three core cycles
	// a disable may cut the high phase short; that is not a timing fault
	chk_pclk_high: assert property ($rose(pclk_o) |-> (pclk_o || !ctl_oe_o) [*3]) else $error("pixel clock high too short");
	chk_data_hold: assert property (pclk_o && $past(pclk_o) |-> $stable(display_data_lines_o)) else $error("data moved in high phase");
	chk_unr_sticky: assert property (underrun_irq_o && !wr_i && ctl_oe_o |=> underrun_irq_o) else $error("underrun lost");
endmodule

bind lpp_pipeline lpp_pipeline_chk u_chk (.ref_clk_i, .rst_i, .wr_i, .rd_i, .rdata_o, .in_ready_o, .dma_req_o,
	.underrun_irq_o, .display_data_lines_o, .data_oe_o, .gp_oe_o, .pclk_o, .ctl_oe_o, .ppc_own_o);

// File: testbench/lpp_panel_model.sv
`timescale 1ns/1ps
module lpp_panel_model (
	input  wire logic        clr_i,     // pins released: drop history
	input  wire logic        act_i,     // active panel
	input  wire logic        pclk_i,    // pixel clock
	input  wire logic        fclk_i,    // frame clock
	input  wire logic        lclk_i,    // line clock
	input  wire logic        bias_i,    // bias or output enable
	input  wire logic [7:0]  dl_i,      // data lines
	input  wire logic [7:0]  gp_i,      // extra data lines
	output logic      [2:0]  n_o,       // words latched
	output logic      [18:0] pw_o [4]   // latched words
);
	// latch on rising pixel clock; an active panel only while enabled
	always @(posedge pclk_i or posedge clr_i)
		if (clr_i)
			n_o <= 0;
		else if ((!act_i || bias_i) && n_o < 4)
		begin
			pw_o[n_o[1:0]] <= {lclk_i, bias_i, fclk_i, gp_i, dl_i};
			n_o <= n_o + 3'd1;
		end
endmodule

// File: testbench/lpp_pipeline_tb_top.sv
`timescale 1ns/1ps
module lpp_pipeline_tb_top;
	logic        ref_clk_i = 0;
	logic        rst_i = 1;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic        in_valid_i = 0;
	logic        act = 0;
	logic [11:0] addr_i = 0;
	logic [31:0] wdata_i = 0;
	logic [31:0] in_data_i = 0;
	logic [31:0] rdata_o;
	logic [31:0] rv;
	logic        in_ready_o, underrun_irq_o, pclk_o, lclk_o, fclk_o, bias_o, ctl_oe_o, ppc_own_o;
	logic [1:0]  dma_req_o;
	logic [7:0]  display_data_lines_o, data_oe_o, gp_data_o, gp_oe_o;
	logic [2:0]  pn;
	logic [18:0] pw [4];
	int          errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	lpp_pipeline DUT (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .in_valid_i, .in_data_i,
		.in_ready_o, .dma_req_o, .underrun_irq_o, .display_data_lines_o, .data_oe_o, .gp_data_o, .gp_oe_o,
		.pclk_o, .lclk_o, .fclk_o, .bias_o, .ctl_oe_o, .ppc_own_o);
	lpp_panel_model u_panel (.clr_i(ppc_own_o), .act_i(act), .pclk_i(pclk_o), .fclk_i(fclk_o), .lclk_i(lclk_o),
		.bias_i(bias_o),
		.dl_i(display_data_lines_o), .gp_i(gp_data_o), .n_o(pn), .pw_o(pw));

	initial
		forever #50 ref_clk_i = ~ref_clk_i;

	task automatic wrap_up;
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard, far above the longest run
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			wrap_up;
		end
	end

	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %s exp %h seen %h", s, exp, seen);
		end
	endtask

	// one register access; read data taken the cycle after
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 0;
		rd_i <= 0;
		#1 rv = rdata_o;
	endtask

	// offer a word until taken, then scramble the idle data
	task automatic push(input logic [31:0] w);
		@(posedge ref_clk_i);
		in_valid_i <= 1;
		in_data_i <= w;
		@(negedge ref_clk_i);
		while (in_ready_o !== 1'b1) @(negedge ref_clk_i);
		@(posedge ref_clk_i);
		in_valid_i <= 0;
		in_data_i <= ~w;
	endtask

	// restart in a mode, stream three words, judge the first two pin words
	task automatic run(input logic [31:0] c, w, e0, e1, m, oe);
		int k;
		bus(1, 12'h000, 0);
		act <= c[4];
		bus(1, 12'h000, c);
		@(negedge ref_clk_i);
		chk("req", dma_req_o, {c[5], 1'b1});
		chk("oe", {gp_oe_o, data_oe_o}, oe);
		push(w);
		push(32'h00000fff);
		push(0);
		for (k = 0; k < 600 && pn < 2; k++) @(negedge ref_clk_i);
		chk("w0", pw[0] & m, e0);
		chk("w1", pw[1] & m, e1);
		chk("fclk", pw[0][16], 1);
	endtask

	// pixel clock period follows the divisor
	task automatic period();
		time t0;
		bus(1, 12'h004, 4);
		@(posedge pclk_o);
		@(posedge pclk_o);
		t0 = $time;
		@(posedge pclk_o);
		chk("per", 32'(($time - t0) / 100), 10);
	endtask

	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 0;
		@(negedge ref_clk_i);
		chk("rst", {ppc_own_o, data_oe_o, in_ready_o, dma_req_o}, 12'h800);
		bus(1, 12'h7fc, 32'hffffffff);
		bus(0, 12'h7fc, 0);
		chk("pal", rv, 32'hfff);
		bus(0, 12'h100, 0);
		chk("unmap", rv, 0);
		bus(1, 12'h404, 32'h00f);
		bus(1, 12'h408, 32'hff0);
		bus(1, 12'h414, 32'habc);
		bus(1, 12'h008, 32'h00010007);
		run(32'h01, 32'h21011021, 9, 5, 32'hf, 32'h000f);
		// eight columns on four lines: the second word closes the line
		chk("lclk0", pw[0][18], 0);
		chk("lclk1", pw[1][18], 1);
		repeat (60) @(negedge ref_clk_i);
		chk("unr", underrun_irq_o, 1);
		bus(0, 12'h00c, 0);
		chk("stat", rv[0], 1);
		run(32'h21, 32'h21011021, 32'h2d, 0, 32'hff, 32'h00ff);
		run(32'h0d, 32'h00f00f0f, 32'hd5, 1, 32'hff, 32'h00ff);
		run(32'h17, 32'hbeef1234, 32'h1234, 32'hbeef, 32'hffff, 32'hffff);
		run(32'h13, 32'h000005ff, 32'hfff, 32'habc, 32'hffff, 32'hffff);
		period();
		bus(1, 12'h000, 0);
		@(negedge ref_clk_i);
		chk("off", {ppc_own_o, data_oe_o, gp_oe_o}, 32'h10000);
		wrap_up;
	end
endmodule
